// ==== tb/tcct_pin_model.sv ====
module tcct_pin_model (
  // Outside source and timer side of the pin
  input  wire drive_i,
  input  wire dut_out_i,
  input  wire dut_oe_n_i,
  // Resolved pin level
  output wire pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // The source yields whenever the timer drives the pin
  assign pin_o = dut_oe_n_i ? drive_i : dut_out_i;
endmodule // tcct_pin_model

// ==== tb/tcct_timer_properties.sv ====
module tcct_timer_properties (
  // Timer ports under watch
  input wire       clk_i,
  input wire       nrst_i,
  input wire [3:0] addr_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       ovf_irq_o,
  input wire       ch0_irq_o,
  input wire       ch1_irq_o,
  input wire       channel0_pin_oe_n_o,
  input wire       channel1_pin_oe_n_o,
  input wire       channel0_pin_timer_o,
  input wire       channel1_pin_timer_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd_i && addr_i > 4'hA |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_reset_bit_zero: assert property (rd_i && addr_i == 4'h0 |=> !rdata_o[4])
    else $error("counter reset bit read back as one");
  a_ovf_clear_cause: assert property ($fell(ovf_irq_o) |-> $past(wr_i && addr_i == 4'h0))
    else $error("overflow request dropped without status write");
  a_ch0_clear_cause: assert property ($fell(ch0_irq_o) |-> $past(wr_i && addr_i == 4'h5))
    else $error("channel 0 request dropped without write");
  a_ch1_clear_cause: assert property ($fell(ch1_irq_o) |->
    $past(wr_i && (addr_i == 4'h8 || addr_i == 4'h5)))
    else $error("channel 1 request dropped without write");
  a_ch0_port_free: assert property (!channel0_pin_timer_o |-> channel0_pin_oe_n_o)
    else $error("channel 0 drives a port pin");
  a_ch1_port_free: assert property (!channel1_pin_timer_o |-> channel1_pin_oe_n_o)
    else $error("channel 1 drives a port pin");

  c_ovf: cover property ($rose(ovf_irq_o));
  c_ch0: cover property ($rose(ch0_irq_o));
  c_ch1: cover property ($rose(ch1_irq_o));
endmodule // tcct_timer_properties

// ==== tb/test_tcct_timer.sv ====
`include "tcct_consts.vh"

module test_tcct_timer;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       lvl0 = 1'b0;
  logic       lvl1 = 1'b1;
  logic [7:0] rdata_o, q, q2;
  logic       ovf_irq_o, ch0_irq_o, ch1_irq_o;
  logic       p0_i, p1_i, p0_o, p1_o, oe0_n, oe1_n, own0, own1;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         n;

  always #2 clk_i = ~clk_i;

  tcct_timer u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ovf_irq_o(ovf_irq_o),
    .ch0_irq_o(ch0_irq_o), .ch1_irq_o(ch1_irq_o), .channel0_pin_i(p0_i),
    .channel1_pin_i(p1_i), .channel0_pin_o(p0_o), .channel1_pin_o(p1_o),
    .channel0_pin_oe_n_o(oe0_n), .channel1_pin_oe_n_o(oe1_n),
    .channel0_pin_timer_o(own0), .channel1_pin_timer_o(own1));
  tcct_pin_model u_pin0 (.drive_i(lvl0), .dut_out_i(p0_o), .dut_oe_n_i(oe0_n), .pin_o(p0_i));
  tcct_pin_model u_pin1 (.drive_i(lvl1), .dut_out_i(p1_o), .dut_oe_n_i(oe1_n), .pin_o(p1_i));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    rd(a, q);
    chk(nm, q, e);
  endtask

  // Clears a channel flag by the read then write-zero sequence
  task automatic clr(input logic [3:0] a);
    rd(a, q);
    wr(a, q & 8'h7F);
  endtask

  // Counts high samples of the channel 0 pin over two periods, after settling
  task automatic hi_count(output int k);
    repeat (20) @(posedge clk_i);
    k = 0;
    repeat (20) begin
      @(posedge clk_i);
      #1;
      if (p0_o === 1'b1) k++;
    end
  endtask

  task automatic test_done;
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100us;
    num_errors++;
    test_done;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdc("status", 4'h0, `TCCT_RST_TSC);
    rdc("mod_hi", 4'h3, 8'hFF);
    rdc("mod_lo", 4'h4, 8'hFF);
    rdc("cnt_lo", 4'h2, 8'h00);
    rdc("ch0_sc", 4'h5, 8'h00);
    rdc("unmapped", 4'hB, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h09);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h36);
    wr(4'h0, 8'h46);
    repeat (1400) @(posedge clk_i);
    chk("ovf_held", 8'(ovf_irq_o), 8'h00);
    wr(4'h4, 8'h09);
    wr(4'h0, 8'h36);
    rdc("status", 4'h0, 8'h26);
    rdc("cnt_hi", 4'h1, 8'h00);
    rdc("cnt_lo", 4'h2, 8'h00);
    wr(4'h0, 8'h46);
    n = 0;
    while (ovf_irq_o !== 1'b1 && n < 800) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("ovf_irq", 8'(ovf_irq_o), 8'h01);
    chk("period", 8'(n >= 570 && n <= 650), 8'h01);
    wr(4'h0, 8'h46);
    chk("ovf_no_read", 8'(ovf_irq_o), 8'h01);
    rdc("status", 4'h0, 8'hC6);
    wr(4'h0, 8'hC6);
    chk("ovf_write1", 8'(ovf_irq_o), 8'h01);
    rdc("status", 4'h0, 8'hC6);
    wr(4'h0, 8'h46);
    chk("ovf_clear", 8'(ovf_irq_o), 8'h00);
    wr(4'h0, 8'h06);
    rd(4'h1, q);
    repeat (140) @(posedge clk_i);
    rd(4'h1, q);
    repeat (140) @(posedge clk_i);
    rd(4'h2, q);
    rd(4'h2, q2);
    n = (q2 + 10 - q) % 10;
    chk("cnt_latch", 8'(n == 4 || n == 5), 8'h01);
    for (int c = 1; c < 4; c++) begin
      wr(4'h5, 8'h40 | 8'(c << 2));
      clr(4'h5);
      lvl0 <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk("rise", 8'(ch0_irq_o), 8'(c[0]));
      clr(4'h5);
      lvl0 <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("fall", 8'(ch0_irq_o), 8'(c[1]));
      clr(4'h5);
    end
    chk("own0", 8'(own0), 8'h01);
    wr(4'h0, 8'h26);
    lvl0 <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("halt_capt", 8'(ch0_irq_o), 8'h00);
    wr(4'h9, 8'h00);
    wr(4'hA, 8'h05);
    wr(4'h8, 8'h10);
    chk("own1", 8'(own1), 8'h00);
    @(posedge clk_i);
    #1;
    chk("preset", 8'(p1_o), 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, 8'h30);
      wr(4'h8, 8'h50 | (8'(3 - i) << 2));
      wr(4'h0, 8'h00);
      repeat (6) @(posedge clk_i);
      wr(4'h0, 8'h20);
      chk("cmp_pin", 8'(p1_o), 8'(i != 1));
    end
    chk("oe1_n", 8'(oe1_n), 8'h00);
    chk("ch1_irq", 8'(ch1_irq_o), 8'h01);
    wr(4'h5, 8'h20);
    chk("own1_buf", 8'(own1), 8'h00);
    rdc("ch1_sc", 4'h8, 8'h00);
    wr(4'h0, 8'h30);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h05);
    wr(4'h5, 8'h1A);
    wr(4'h0, 8'h00);
    chk("oe0_n", 8'(oe0_n), 8'h00);
    hi_count(n);
    chk("pwm_duty", 8'(n), 8'h0C);
    wr(4'h5, 8'h1B);
    hi_count(n);
    chk("full_duty", 8'(n), 8'h14);
    wr(4'h5, 8'h1A);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h09);
    hi_count(n);
    chk("ovf_wins", 8'(n), 8'h0A);
    wr(4'h6, 8'h00);
    clr(4'h5);
    repeat (30) @(posedge clk_i);
    rdc("cmp_block", 4'h5, 8'h1A);
    wr(4'h7, 8'h09);
    repeat (12) @(posedge clk_i);
    rdc("cmp_resume", 4'h5, 8'h9A);
    test_done;
  end
endmodule // test_tcct_timer

bind tcct_timer tcct_timer_properties u_props (.clk_i(clk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ovf_irq_o(ovf_irq_o),
  .ch0_irq_o(ch0_irq_o), .ch1_irq_o(ch1_irq_o),
  .channel0_pin_oe_n_o(channel0_pin_oe_n_o), .channel1_pin_oe_n_o(channel1_pin_oe_n_o),
  .channel0_pin_timer_o(channel0_pin_timer_o),
  .channel1_pin_timer_o(channel1_pin_timer_o));

// ==== verilog/tcct_consts.vh ====
`ifndef TCCT_CONSTS_VH
`define TCCT_CONSTS_VH
// Register indices (byte wide registers, one per address)
`define TCCT_ADDR_W          4
`define TCCT_REG_TSC         4'h0
`define TCCT_REG_CNTH        4'h1
`define TCCT_REG_CNTL        4'h2
`define TCCT_REG_MODH        4'h3
`define TCCT_REG_MODL        4'h4
`define TCCT_REG_CH0SC       4'h5
`define TCCT_REG_CH0H        4'h6
`define TCCT_REG_CH0L        4'h7
`define TCCT_REG_CH1SC       4'h8
`define TCCT_REG_CH1H        4'h9
`define TCCT_REG_CH1L        4'hA
// Timer status/control fields
`define TCCT_TSC_OVF         7
`define TCCT_TSC_OVIE        6
`define TCCT_TSC_HALT        5
`define TCCT_TSC_CRST        4
`define TCCT_TSC_PS_HI       2
`define TCCT_TSC_PS_LO       0
// Channel status/control fields
`define TCCT_CSC_FLAG        7
`define TCCT_CSC_IE          6
`define TCCT_CSC_MSB         5
`define TCCT_CSC_MSA         4
`define TCCT_CSC_ELB         3
`define TCCT_CSC_ELA         2
`define TCCT_CSC_TOV         1
`define TCCT_CSC_MAX         0
// Reset values
`define TCCT_RST_TSC         8'h20
`define TCCT_RST_MOD         16'hFFFF
`endif

// ==== verilog/tcct_timer.v ====
// Summary of operation
// - Each channel pin is capture input or compare output; only channel 0 buffers.
// - Overflow flag sets when counter reaches modulo; reset clears it.
// - Overflow flag clears by read-with-flag-set then write 0; new overflow cancels.
// - Overflow interrupt requested while flag and enable are both set.
// - Halt bit holds counter; reset sets halt.
// - While halted, capture channels ignore edges.
// - Counter reset bit clears counter and prescaler, self-clears, reads zero.
// - Halt plus counter reset in one write leaves counter halted at zero.
// - Prescale codes 0..6 divide bus clock by 1..64; code 7 unavailable.
// - Counter high read latches low byte until low byte is read.
// - At modulo, counter restarts from zero next timer tick; modulo resets to ones.
// - Modulo high write suppresses overflow until modulo low written.
// - Channel flag sets on active capture edge or compare match.
// - Channel flag clears by read-with-flag-set then write 0; new event cancels.
// - Channel interrupt requested while channel flag and enable both set.
// - Buffered bit only on channel 0; it disables channel 1 and frees its pin.
// - Mode A picks capture or compare, or preset level when edge bits are 00.
// - Edge bits 00 disconnect the channel; pin goes to port control.
// - Capture edge code 01 rising, 10 falling, 11 both.
// - Compare code 00 software only, 01 toggle, 10 clear, 11 set.
// - Toggle-at-overflow toggles pin on overflow, beating a coincident compare.
// - Full duty force with toggle-at-overflow gives 100% duty from next period.
// - Channel high read blocks capture, high write blocks compare, until low access.
//
// Our own choices: the register addresses and the address-and-strobe port.
`include "tcct_consts.vh"

module tcct_timer (
  // Clock and reset
  input  wire                    clk_i,
  input  wire                    nrst_i,
  // Register port
  input  wire [`TCCT_ADDR_W-1:0] addr_i,
  input  wire [7:0]              wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [7:0]              rdata_o,
  // Interrupt requests
  output wire                    ovf_irq_o,
  output wire                    ch0_irq_o,
  output wire                    ch1_irq_o,
  // Channel pins
  input  wire                    channel0_pin_i,
  input  wire                    channel1_pin_i,
  output wire                    channel0_pin_o,
  output wire                    channel1_pin_o,
  output wire                    channel0_pin_oe_n_o,
  output wire                    channel1_pin_oe_n_o,
  output wire                    channel0_pin_timer_o,
  output wire                    channel1_pin_timer_o
);

  // Control and status
  reg        ovf_r;
  reg        ovie_r;
  reg        halt_r;
  reg        ovf_armed_r;
  reg  [2:0] psel_r;
  reg  [6:0] presc_r;
  reg [15:0] cnt_r;
  reg [15:0] mod_r;
  reg  [7:0] mod_hi_buf_r;
  reg        mod_lock_r;
  reg  [7:0] cnt_lo_latch_r;
  reg        cnt_latched_r;
  // Channels
  reg  [1:0] flag_r;
  reg  [1:0] flag_armed_r;
  reg  [1:0] ie_r;
  reg  [1:0] msa_r;
  reg  [1:0] elb_r;
  reg  [1:0] ela_r;
  reg  [1:0] tov_r;
  reg  [1:0] max_r;
  reg        msb_r;
  reg [15:0] chv0_r;
  reg [15:0] chv1_r;
  reg  [7:0] ch_hi_buf_r [0:1];
  reg  [1:0] ch_lock_r;
  reg  [1:0] pin_lvl_r;
  reg  [1:0] max_eff_r;
  reg        buf_sel_r;
  reg        buf_pend_r;
  // Pin synchronisers
  reg  [1:0] pin_s1_r;
  reg  [1:0] pin_s2_r;
  reg  [1:0] pin_d_r;
  reg  [2:0] pin_age_r;

  wire [1:0] pin_in = {channel1_pin_i, channel0_pin_i};

  // Prescaler tick
  reg tick;
  // Code 7 never ticks, so the counter stays frozen
  always @* begin
    case (psel_r)
      3'h0: tick = 1'b1;
      3'h1: tick = presc_r[0];
      3'h2: tick = &presc_r[1:0];
      3'h3: tick = &presc_r[2:0];
      3'h4: tick = &presc_r[3:0];
      3'h5: tick = &presc_r[4:0];
      3'h6: tick = &presc_r[5:0];
      default: tick = 1'b0;
    endcase
  end

  // A counter reset write wins over a tick in the same cycle
  wire rst_wr   = wr_i && (addr_i == `TCCT_REG_TSC) && wdata_i[`TCCT_TSC_CRST];
  wire step     = !halt_r && tick && !rst_wr;
  wire at_mod   = (cnt_r == mod_r);
  wire ovf_ev   = step && at_mod && !mod_lock_r;

  // Channel mode decode
  wire [1:0] el_on;
  wire [1:0] is_cap;
  wire [1:0] is_cmp;
  wire [1:0] active;
  assign active[0] = 1'b1;
  assign active[1] = !msb_r;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_mode
      assign el_on[g]  = elb_r[g] | ela_r[g];
      assign is_cap[g] = active[g] && el_on[g] && !msa_r[g] &&
                         !(g == 0 && msb_r);
      assign is_cmp[g] = active[g] && (msa_r[g] || (g == 0 && msb_r));
    end
  endgenerate

  // Capture edges; halt blocks capture
  // Edges count only once the synchroniser holds real pin samples
  wire       pin_ok = pin_age_r[2];
  wire [1:0] rise = pin_s2_r & ~pin_d_r & {2{pin_ok}};
  wire [1:0] fall = ~pin_s2_r & pin_d_r & {2{pin_ok}};
  wire [1:0] cap_ev;
  wire [1:0] cmp_ev;
  // Buffered mode: the value set written last drives channel 0
  wire [15:0] chv_use0 = (msb_r && buf_sel_r) ? chv1_r : chv0_r;
  assign cap_ev[0] = is_cap[0] && !halt_r && !ch_lock_r[0] &&
                     ((ela_r[0] && rise[0]) || (elb_r[0] && fall[0]));
  assign cap_ev[1] = is_cap[1] && !halt_r && !ch_lock_r[1] &&
                     ((ela_r[1] && rise[1]) || (elb_r[1] && fall[1]));
  // Compare on the tick taken while the counter holds the value
  assign cmp_ev[0] = is_cmp[0] && step && (cnt_r == chv_use0) && !ch_lock_r[0];
  assign cmp_ev[1] = is_cmp[1] && step && (cnt_r == chv1_r) && !ch_lock_r[1];
  wire [1:0] ch_ev = cap_ev | cmp_ev;

  wire [1:0] csc_wr;
  wire [1:0] csc_rd;
  assign csc_wr[0] = wr_i && addr_i == `TCCT_REG_CH0SC;
  assign csc_wr[1] = wr_i && addr_i == `TCCT_REG_CH1SC && !msb_r;
  assign csc_rd[0] = rd_i && addr_i == `TCCT_REG_CH0SC;
  assign csc_rd[1] = rd_i && addr_i == `TCCT_REG_CH1SC && !msb_r;

  // Pin path
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_d_r  <= 2'h0;
      pin_age_r <= 3'h0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
      pin_age_r <= {pin_age_r[1:0], 1'b1};
    end
  end

  // Timer status, counter, modulo
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_r          <= 1'b0;
      ovf_armed_r    <= 1'b0;
      ovie_r         <= 1'b0;
      halt_r         <= 1'b1;
      psel_r         <= 3'h0;
      presc_r        <= 7'h00;
      cnt_r          <= 16'h0000;
      mod_r          <= `TCCT_RST_MOD;
      mod_hi_buf_r   <= 8'hFF;
      mod_lock_r     <= 1'b0;
      cnt_lo_latch_r <= 8'h00;
      cnt_latched_r  <= 1'b0;
    end else begin
      // A status read with the flag set arms the clear; an overflow disarms it
      if (rd_i && addr_i == `TCCT_REG_TSC && ovf_r)
        ovf_armed_r <= 1'b1;
      if (ovf_ev) begin
        ovf_r       <= 1'b1;
        ovf_armed_r <= 1'b0;
      end else if (wr_i && addr_i == `TCCT_REG_TSC) begin
        if (!wdata_i[`TCCT_TSC_OVF] && ovf_armed_r)
          ovf_r <= 1'b0;
        ovf_armed_r <= 1'b0;
      end
      if (wr_i && addr_i == `TCCT_REG_TSC) begin
        ovie_r <= wdata_i[`TCCT_TSC_OVIE];
        halt_r <= wdata_i[`TCCT_TSC_HALT];
        psel_r <= wdata_i[`TCCT_TSC_PS_HI:`TCCT_TSC_PS_LO];
      end
      if (rst_wr) begin
        cnt_r   <= 16'h0000;
        presc_r <= 7'h00;
      end else if (!halt_r) begin
        presc_r <= presc_r + 7'h01;
        if (step)
          cnt_r <= at_mod ? 16'h0000 : cnt_r + 16'h0001;
      end
      // The high byte waits in a buffer so the 16-bit modulo changes at once
      if (wr_i && addr_i == `TCCT_REG_MODH) begin
        mod_hi_buf_r <= wdata_i;
        mod_lock_r   <= 1'b1;
      end
      if (wr_i && addr_i == `TCCT_REG_MODL) begin
        mod_r      <= {mod_hi_buf_r, wdata_i};
        mod_lock_r <= 1'b0;
      end
      // Freezing the low byte keeps a two-read counter value coherent
      if (rd_i && addr_i == `TCCT_REG_CNTH && !cnt_latched_r) begin
        cnt_lo_latch_r <= cnt_r[7:0];
        cnt_latched_r  <= 1'b1;
      end else if (rd_i && addr_i == `TCCT_REG_CNTL) begin
        cnt_latched_r <= 1'b0;
      end
    end
  end

  // Channel registers and pin behaviour
  integer i;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_r       <= 2'h0;
      flag_armed_r <= 2'h0;
      ie_r         <= 2'h0;
      msb_r        <= 1'b0;
      msa_r        <= 2'h0;
      elb_r        <= 2'h0;
      ela_r        <= 2'h0;
      tov_r        <= 2'h0;
      max_r        <= 2'h0;
      max_eff_r    <= 2'h0;
      chv0_r       <= 16'h0000;
      chv1_r       <= 16'h0000;
      ch_hi_buf_r[0] <= 8'h00;
      ch_hi_buf_r[1] <= 8'h00;
      ch_lock_r    <= 2'h0;
      pin_lvl_r    <= 2'h3;
      buf_sel_r    <= 1'b0;
      buf_pend_r   <= 1'b0;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        // Same two-step clear as the overflow flag
        if (csc_rd[i] && flag_r[i])
          flag_armed_r[i] <= 1'b1;
        if (ch_ev[i]) begin
          flag_r[i]       <= 1'b1;
          flag_armed_r[i] <= 1'b0;
        end else if (csc_wr[i]) begin
          if (!wdata_i[`TCCT_CSC_FLAG] && flag_armed_r[i])
            flag_r[i] <= 1'b0;
          flag_armed_r[i] <= 1'b0;
        end
        if (csc_wr[i]) begin
          ie_r[i]  <= wdata_i[`TCCT_CSC_IE];
          msa_r[i] <= wdata_i[`TCCT_CSC_MSA];
          elb_r[i] <= wdata_i[`TCCT_CSC_ELB];
          ela_r[i] <= wdata_i[`TCCT_CSC_ELA];
          tov_r[i] <= wdata_i[`TCCT_CSC_TOV];
          max_r[i] <= wdata_i[`TCCT_CSC_MAX];
        end
        // Pin level: preset, overflow toggle, compare action
        if (!el_on[i] || !(is_cap[i] || is_cmp[i])) begin
          if (!(i == 0 && msb_r && el_on[i]))
            pin_lvl_r[i] <= !msa_r[i];
        end
        if (is_cmp[i] && ovf_ev)
          max_eff_r[i] <= max_r[i];
        // Overflow beats a coincident compare only while it toggles the pin
        if (is_cmp[i] && ovf_ev && tov_r[i]) begin
          pin_lvl_r[i] <= (max_r[i] && !ela_r[i]) ? 1'b1 :
                          (max_r[i] && ela_r[i] && elb_r[i]) ? 1'b0 :
                          !pin_lvl_r[i];
        end else if (cmp_ev[i] && !(tov_r[i] && max_eff_r[i])) begin
          case ({elb_r[i], ela_r[i]})
            2'b01: pin_lvl_r[i] <= !pin_lvl_r[i];
            2'b10: pin_lvl_r[i] <= 1'b0;
            2'b11: pin_lvl_r[i] <= 1'b1;
            default: pin_lvl_r[i] <= pin_lvl_r[i];
          endcase
        end
      end
      // Only channel 0 carries the buffered bit
      if (csc_wr[0])
        msb_r <= wdata_i[`TCCT_CSC_MSB];
      // Channel value access with high-byte blocking
      if (rd_i && addr_i == `TCCT_REG_CH0H && is_cap[0]) ch_lock_r[0] <= 1'b1;
      if (rd_i && addr_i == `TCCT_REG_CH0L && is_cap[0]) ch_lock_r[0] <= 1'b0;
      if (rd_i && addr_i == `TCCT_REG_CH1H && is_cap[1]) ch_lock_r[1] <= 1'b1;
      if (rd_i && addr_i == `TCCT_REG_CH1L && is_cap[1]) ch_lock_r[1] <= 1'b0;
      if (wr_i && addr_i == `TCCT_REG_CH0H) begin
        ch_hi_buf_r[0] <= wdata_i;
        if (!is_cap[0]) ch_lock_r[0] <= 1'b1;
      end
      if (wr_i && addr_i == `TCCT_REG_CH1H) begin
        ch_hi_buf_r[1] <= wdata_i;
        if (!is_cap[1]) ch_lock_r[1] <= 1'b1;
      end
      if (wr_i && addr_i == `TCCT_REG_CH0L) begin
        chv0_r       <= {ch_hi_buf_r[0], wdata_i};
        ch_lock_r[0] <= 1'b0;
        buf_pend_r   <= 1'b0;
      end
      if (wr_i && addr_i == `TCCT_REG_CH1L) begin
        chv1_r       <= {ch_hi_buf_r[1], wdata_i};
        ch_lock_r[1] <= 1'b0;
        buf_pend_r   <= 1'b1;
      end
      // Buffered mode: last written channel value takes over at overflow
      if (!msb_r)
        buf_sel_r <= 1'b0;
      else if (ovf_ev)
        buf_sel_r <= buf_pend_r;
      if (cap_ev[0]) chv0_r <= cnt_r;
      if (cap_ev[1]) chv1_r <= cnt_r;
    end
  end

  // Interrupt requests
  assign ovf_irq_o = ovf_r & ovie_r;
  assign ch0_irq_o = flag_r[0] & ie_r[0];
  assign ch1_irq_o = flag_r[1] & ie_r[1] & active[1];

  // Pins: channel drives only in compare mode with edge bits set
  wire [1:0] drive = is_cmp & el_on;
  assign channel0_pin_o       = pin_lvl_r[0];
  assign channel1_pin_o       = pin_lvl_r[1];
  assign channel0_pin_oe_n_o  = !drive[0];
  assign channel1_pin_oe_n_o  = !drive[1];
  assign channel0_pin_timer_o = el_on[0];
  assign channel1_pin_timer_o = el_on[1] & active[1];

  // Read data, one cycle after the strobe
  wire [7:0] tsc_rd = {ovf_r, ovie_r, halt_r, 2'b00, psel_r};
  wire [7:0] ch0_rd = {flag_r[0], ie_r[0], msb_r, msa_r[0], elb_r[0], ela_r[0],
                       tov_r[0], max_r[0]};
  wire [7:0] ch1_rd = {flag_r[1], ie_r[1], 1'b0, msa_r[1], elb_r[1], ela_r[1],
                       tov_r[1], max_r[1]};
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `TCCT_REG_TSC) rdata_o <= tsc_rd;
      else if (addr_i == `TCCT_REG_CNTH) rdata_o <= cnt_r[15:8];
      else if (addr_i == `TCCT_REG_CNTL)
        rdata_o <= cnt_latched_r ? cnt_lo_latch_r : cnt_r[7:0];
      else if (addr_i == `TCCT_REG_MODH) rdata_o <= mod_r[15:8];
      else if (addr_i == `TCCT_REG_MODL) rdata_o <= mod_r[7:0];
      else if (addr_i == `TCCT_REG_CH0SC) rdata_o <= ch0_rd;
      else if (addr_i == `TCCT_REG_CH0H) rdata_o <= chv0_r[15:8];
      else if (addr_i == `TCCT_REG_CH0L) rdata_o <= chv0_r[7:0];
      else if (addr_i == `TCCT_REG_CH1SC) rdata_o <= msb_r ? 8'h00 : ch1_rd;
      else if (addr_i == `TCCT_REG_CH1H) rdata_o <= chv1_r[15:8];
      else if (addr_i == `TCCT_REG_CH1L) rdata_o <= chv1_r[7:0];
      else rdata_o <= 8'h00;
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // tcct_timer
